// >>> sim/rtc_alarm_compare_props.sv
// port checker for the alarm compare block
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_compare_props (
  // clock, reset, apb
  input wire logic        SYS_CLK, RESET, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA, PRDATA,
  // time and alarm
  input wire logic        TIME_TICK, IRQ, ALARM_PULSE, ALARM_ZERO_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // only the control bits are shadowed; match registers are judged by the bench
  logic [7:0] ctl;
  wire tk = TIME_TICK && CE;
  wire acc = PSEL && PENABLE && PREADY;
  wire rd_st = acc && !PWRITE && PADDR == 8'h1C;
  wire en0 = ctl[5];
  wire rep = ctl[7];
  always_ff @(posedge SYS_CLK or posedge RESET)
    if (RESET) ctl <= 8'h00;
    else if (acc && PWRITE && PADDR == 8'h18) ctl <= PWDATA[7:0];
  a_ready_needs_enable: assert property (PREADY |-> CE)
    else $error("ready while clock enable low");
  a_freeze_on_ce: assert property (!CE |=> $stable(ALARM_ZERO_FLAG) && $stable(ALARM_PULSE) && $stable(PRDATA))
    else $error("state changed while clock enable low");
  a_rise_on_tick: assert property ($rose(ALARM_ZERO_FLAG) |-> $past(tk))
    else $error("flag rose without a tick");
  a_rise_needs_enable: assert property ($rose(ALARM_ZERO_FLAG) |-> $past(en0))
    else $error("flag rose while alarm disabled");
  a_pulse_single: assert property (ALARM_PULSE && CE |=> !ALARM_PULSE)
    else $error("pulse longer than one cycle");
  a_pulse_repeat: assert property (ALARM_PULSE |-> $past(rep) && ALARM_ZERO_FLAG)
    else $error("pulse outside repeat mode or without flag");
  a_irq_has_flag: assert property (IRQ |-> ALARM_ZERO_FLAG)
    else $error("interrupt without flag");
  a_flag_sticky: assert property ($fell(ALARM_ZERO_FLAG) |-> $past(rd_st))
    else $error("flag cleared without status read");
  a_read_upper_zero: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_error: assert property (acc && PADDR > 8'h27 |-> PSLVERR)
    else $error("no error on unmapped address");
  c_fire: cover property ($rose(ALARM_ZERO_FLAG));
  c_pulse: cover property (ALARM_PULSE);
  c_clear: cover property ($fell(ALARM_ZERO_FLAG));
  c_stall: cover property (PSEL && PENABLE && !PREADY);
endmodule // rtc_alarm_compare_props
`default_nettype wire

// >>> sim/rtc_alarm_compare_test.sv
// self-checking bench for the alarm compare block
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_compare_test;
  logic        SYS_CLK = 0, RESET = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, TIME_TICK = 0, err;
  logic [7:0]  PADDR = 0, TIME_SECONDS = 0, TIME_MINUTES = 0, TIME_HOURS = 0;
  logic [7:0]  TIME_DATE = 0, TIME_MONTH = 0, TIME_WEEKDAY = 0, w;
  logic [31:0] PWDATA = 0, r, d;
  wire         PREADY, PSLVERR, IRQ, ALARM_PULSE, ALARM_ZERO_FLAG;
  wire  [31:0] PRDATA;
  logic [7:0]  ex1[7] = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00, 8'h00};
  logic [7:0]  ex2[7] = '{8'hB0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0};
  int          bad_count = 0, num_checks = 0, k;
  rtc_alarm_compare i_dut (
    .SYS_CLK (SYS_CLK), .RESET (RESET), .CE (CE), .PSEL (PSEL), .PENABLE (PENABLE), .PWRITE (PWRITE),
    .PADDR (PADDR), .PWDATA (PWDATA), .PREADY (PREADY), .PRDATA (PRDATA), .PSLVERR (PSLVERR),
    .TIME_TICK (TIME_TICK), .TIME_SECONDS (TIME_SECONDS), .TIME_MINUTES (TIME_MINUTES),
    .TIME_HOURS (TIME_HOURS), .TIME_DATE (TIME_DATE), .TIME_MONTH (TIME_MONTH), .TIME_WEEKDAY (TIME_WEEKDAY),
    .IRQ (IRQ), .ALARM_PULSE (ALARM_PULSE), .ALARM_ZERO_FLAG (ALARM_ZERO_FLAG)
  );
  initial forever #50 SYS_CLK = ~SYS_CLK;
  function logic [7:0] bcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  task summarize;
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    @(posedge SYS_CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, wr, a, dat};
    @(posedge SYS_CLK);
    PENABLE <= 1;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (PREADY !== 1'b1 && n < 50);
    if (n == 50) begin chk(0, 1); summarize; end
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  // one tick, then look at pulse and flag in the cycle after it
  task tick(input logic [7:0] s, m, h, logic ep, ef);
    @(posedge SYS_CLK);
    {TIME_TICK, TIME_SECONDS, TIME_MINUTES, TIME_HOURS} <= {1'b1, s, m, h};
    {TIME_DATE, TIME_MONTH, TIME_WEEKDAY} <= {8'h01, 8'h01, w};
    @(posedge SYS_CLK);
    TIME_TICK <= 0;
    #1;
    chk(ALARM_PULSE, ep);
    chk(ALARM_ZERO_FLAG, ef);
  endtask
  initial begin
    void'($urandom(32));
    w = bcd($urandom % 7 + 1);
    repeat (3) @(posedge SYS_CLK);
    RESET <= 0;
    for (k = 0; k < 9; k++) begin
      apb(0, 8'(k * 4), 0);
      chk(r, 0);
    end
    for (k = 0; k < 6; k++) begin
      d = $urandom;
      apb(1, 8'(k * 4), d);
      apb(0, 8'(k * 4), 0);
      chk(r, {24'h000000, d[7:0]});
    end
    apb(0, 8'h40, 0);
    chk({err, r[30:0]}, 32'h80000000);
    foreach (ex1[i]) apb(1, 8'(i * 4), 32'(ex1[i]));
    apb(1, 8'h20, 1);
    tick(8'h59, 8'h29, 8'h11, 0, 0);
    tick(8'h00, 8'h30, 8'h11, 0, 0);
    apb(1, 8'h18, 32'h20);
    tick(8'h59, 8'h29, 8'h11, 0, 0);
    tick(8'h00, 8'h30, 8'h11, 0, 1);
    chk(IRQ, 1);
    apb(1, 8'h20, 0);
    #1 chk(IRQ, 0);
    apb(0, 8'h1C, 0);
    chk(r, 1);
    #1 chk(ALARM_ZERO_FLAG, 0);
    tick(8'h59, 8'h29, 8'h11, 0, 0);
    tick(8'h00, 8'h30, 8'h11, 0, 0);
    // clock enable low over the setup edge of a read and over a tick: the read waits, the tick is ignored
    @(posedge SYS_CLK);
    CE <= 0;
    fork
      apb(0, 8'h24, 0);
      begin
        tick(8'h59, 8'h29, 8'h11, 0, 0);
        repeat (2) @(posedge SYS_CLK);
        CE <= 1;
      end
    join
    chk(r, 32'h2);
    foreach (ex2[i]) apb(1, 8'(i * 4), 32'(ex2[i]));
    // minutes and hours random: disabled fields must not matter
    for (k = 0; k < 180; k++)
      tick(bcd(k % 60), bcd($urandom % 60), bcd($urandom % 24), k % 60 == 30, k >= 30);
    summarize;
  end
  initial begin
    #1ms;
    chk(0, 1);
    summarize;
  end
endmodule // rtc_alarm_compare_test
bind rtc_alarm_compare rtc_alarm_compare_props i_props (
  .SYS_CLK (SYS_CLK), .RESET (RESET), .CE (CE), .PSEL (PSEL), .PENABLE (PENABLE), .PWRITE (PWRITE),
  .PREADY (PREADY), .PSLVERR (PSLVERR), .PADDR (PADDR), .PWDATA (PWDATA), .PRDATA (PRDATA),
  .TIME_TICK (TIME_TICK), .IRQ (IRQ), .ALARM_PULSE (ALARM_PULSE), .ALARM_ZERO_FLAG (ALARM_ZERO_FLAG)
);
`default_nettype wire

// >>> verilog/alarm_event_status.v
// sticky event status with read-to-clear, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.vh"

module alarm_event_status #(
  parameter EVENTS = 1
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              ce,
  input  wire [EVENTS-1:0] set_evt,
  input  wire [EVENTS-1:0] clear_bits,
  input  wire              mask_we,
  input  wire [EVENTS-1:0] mask_wdata,
  output reg  [EVENTS-1:0] status,
  output reg  [EVENTS-1:0] mask,
  output wire              irq
);

  wire [EVENTS-1:0] next_status;

  // a set in the clearing cycle survives the clear
  assign next_status = (status & ~clear_bits) | set_evt;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= {EVENTS{1'b0}};
      mask   <= {EVENTS{`IRQ_MASK_RESET}};
    end else if (ce) begin
      status <= next_status;
      if (mask_we) begin
        mask <= mask_wdata;
      end
    end
  end

  assign irq = |(status & mask);

endmodule // alarm_event_status
`default_nettype wire

// >>> verilog/alarm_field_compare.v
// per-field comparison of alarm match registers against the current time
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.vh"

module alarm_field_compare #(
  parameter FIELDS = 6
) (
  input  wire [FIELDS*8-1:0] match_bus,
  input  wire [FIELDS*8-1:0] time_bus,
  output wire [FIELDS-1:0]   field_hit,
  output wire                all_match
);

  genvar i;
  generate
    for (i = 0; i < FIELDS; i = i + 1) begin : g_field
      wire [7:0] match_reg;
      wire [7:0] time_val;
      assign match_reg = match_bus[i*8 +: 8];
      assign time_val  = time_bus[i*8 +: 8];
      assign field_hit[i] = ~match_reg[`MATCH_ENABLE_BIT] |
                            (match_reg[`MATCH_VALUE_MSB:0] == time_val[`MATCH_VALUE_MSB:0]);
    end
  endgenerate

  assign all_match = &field_hit;

endmodule // alarm_field_compare
`default_nettype wire

// >>> verilog/rtc_alarm_compare.v
// alarm-zero compare block with APB register access and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "rtc_alarm_regs.vh"

// Summary of operation
// - match register: enable bit seven, BCD value
// - all-zero match register ignores its field
// - repeat select low: alarm fires once
// - alarm needs enable bit five set
// - evaluate when time advances into match
// - match sets alarm_zero_flag in status
// - repeat select bit seven: periodic pulses
// - seconds-only pulsed alarm fires every minute
// - pulsed: flag set each trigger, no clear needed
module rtc_alarm_compare #(
  parameter FIELDS = 6
) (
  // clock, reset, enable
  input  wire        SYS_CLK,
  input  wire        RESET,
  input  wire        CE,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output reg  [31:0] PRDATA,
  output reg         PSLVERR,
  // running time, BCD, valid in the tick cycle
  input  wire        TIME_TICK,
  input  wire [7:0]  TIME_SECONDS,
  input  wire [7:0]  TIME_MINUTES,
  input  wire [7:0]  TIME_HOURS,
  input  wire [7:0]  TIME_DATE,
  input  wire [7:0]  TIME_MONTH,
  input  wire [7:0]  TIME_WEEKDAY,
  // alarm outputs
  output wire        IRQ,
  output reg         ALARM_PULSE,
  output wire        ALARM_ZERO_FLAG
);

  // bus phases
  wire        capture;
  wire        access_done;
  wire        wr_en;
  wire        rd_done;
  reg         rd_loaded;
  reg         addr_hit;
  reg  [31:0] read_mux;
  reg  [7:0]  captured_status;

  // address decode
  wire        sel_control;
  wire        sel_status;
  wire        sel_mask;
  wire        sel_rearm;

  // registers
  wire [FIELDS*8-1:0] match_bus;
  reg  [7:0]          interrupt_control;
  reg                 armed;
  reg                 last_match;

  // compare and events
  wire [FIELDS*8-1:0] time_bus;
  wire [FIELDS-1:0]   field_hit;
  wire                all_match;
  wire                irq_repeat_select;
  wire                alarm_zero_enable;
  wire                match_entered;
  wire                fire_allowed;
  wire                fire;
  wire                match_write;
  wire [0:0]          status;
  wire [0:0]          mask;
  wire [0:0]          clear_bits;
  wire                mask_we;

  // offset of each alarm match field in the same order as time_bus
  function [7:0] field_offset;
    input integer idx;
    begin
      case (idx)
        0:       field_offset = `OFS_ALARM_SECONDS_MATCH;
        1:       field_offset = `OFS_ALARM_MINUTES_MATCH;
        2:       field_offset = `OFS_ALARM_HOURS_MATCH;
        3:       field_offset = `OFS_ALARM_DATE_MATCH;
        4:       field_offset = `OFS_ALARM_MONTH_MATCH;
        default: field_offset = `OFS_ALARM_WEEKDAY_MATCH;
      endcase
    end
  endfunction

  //--- apb slave

  // no wait state unless the clock enable is low over the setup edge or the access edge: read data
  // and error must be captured on an enabled edge before the access may complete
  assign PREADY      = CE & rd_loaded;
  assign capture     = PSEL & ~rd_loaded;
  assign access_done = PSEL & PENABLE & PREADY;
  assign wr_en       = access_done & PWRITE & ~PSLVERR;
  assign rd_done     = access_done & ~PWRITE & ~PSLVERR;

  assign sel_control = PADDR == `OFS_INTERRUPT_CONTROL;
  assign sel_status  = PADDR == `OFS_ALARM_STATUS;
  assign sel_mask    = PADDR == `OFS_IRQ_MASK;
  // match registers and interrupt control sit below the status register
  assign sel_rearm   = PADDR <= `OFS_INTERRUPT_CONTROL;

  always @* begin
    addr_hit = 1'b1;
    read_mux = 32'h0000_0000;
    case (PADDR)
      `OFS_ALARM_SECONDS_MATCH: read_mux[7:0] = match_bus[7:0];
      `OFS_ALARM_MINUTES_MATCH: read_mux[7:0] = match_bus[15:8];
      `OFS_ALARM_HOURS_MATCH:   read_mux[7:0] = match_bus[23:16];
      `OFS_ALARM_DATE_MATCH:    read_mux[7:0] = match_bus[31:24];
      `OFS_ALARM_MONTH_MATCH:   read_mux[7:0] = match_bus[39:32];
      `OFS_ALARM_WEEKDAY_MATCH: read_mux[7:0] = match_bus[47:40];
      `OFS_INTERRUPT_CONTROL:   read_mux[7:0] = interrupt_control;
      `OFS_ALARM_STATUS:        read_mux[`ALARM_ZERO_FLAG_BIT] = status[0];
      `OFS_IRQ_MASK:            read_mux[`ALARM_ZERO_FLAG_BIT] = mask[0];
      `OFS_ALARM_STATE: begin
        read_mux[`STATE_ARMED_BIT]      = armed;
        read_mux[`STATE_LAST_MATCH_BIT] = last_match;
        read_mux[`STATE_MATCH_NOW_BIT]  = all_match;
      end
      default:                  addr_hit = 1'b0;
    endcase
  end

  // read data and error are captured on the first enabled edge of a transfer
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA          <= 32'h0000_0000;
      PSLVERR         <= 1'b0;
      captured_status <= 8'h00;
    end else if (CE) begin
      if (capture) begin
        PRDATA          <= read_mux;
        PSLVERR         <= ~addr_hit;
        captured_status <= read_mux[7:0];
      end
    end
  end

  // marks that the current transfer has its read data and error in place
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rd_loaded <= 1'b0;
    end else if (CE) begin
      if (capture) begin
        rd_loaded <= 1'b1;
      end else if (access_done) begin
        rd_loaded <= 1'b0;
      end
    end
  end

  //--- alarm match and control registers

  genvar i;
  generate
    for (i = 0; i < FIELDS; i = i + 1) begin : g_match_reg
      reg [7:0] field_value;
      always @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
          field_value <= `MATCH_RESET;
        end else if (CE && wr_en && PADDR == field_offset(i)) begin
          field_value <= PWDATA[7:0];
        end
      end
      assign match_bus[i*8 +: 8] = field_value;
    end
  endgenerate

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      interrupt_control <= `INTERRUPT_CONTROL_RESET;
    end else if (CE && wr_en && sel_control) begin
      interrupt_control <= PWDATA[7:0];
    end
  end

  assign irq_repeat_select = interrupt_control[`IRQ_REPEAT_SELECT_BIT];
  assign alarm_zero_enable = interrupt_control[`ALARM_ZERO_ENABLE_BIT];

  //--- comparison

  assign time_bus = {TIME_WEEKDAY, TIME_MONTH, TIME_DATE,
                     TIME_HOURS, TIME_MINUTES, TIME_SECONDS};

  alarm_field_compare #(
    .FIELDS    (FIELDS)
  ) u_compare (
    .match_bus (match_bus),
    .time_bus  (time_bus),
    .field_hit (field_hit),
    .all_match (all_match)
  );

  // any write to a match register or to interrupt control re-arms a single-event alarm
  assign match_write = wr_en & sel_rearm;

  // compare only on the second tick
  // fire on entry into the match
  assign match_entered = TIME_TICK & all_match & ~last_match;

  assign fire_allowed = irq_repeat_select | armed;

  assign fire = match_entered & alarm_zero_enable & fire_allowed;

  // last_match tracks the compare result at each tick so that a field held equal
  // for many seconds (minute resolution) fires once, on the 59 to 00 rollover
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      last_match <= 1'b0;
    end else if (CE) begin
      if (TIME_TICK) begin
        last_match <= all_match;
      end
    end
  end

  // re-arming wins over disarming so a write in the firing cycle is not lost
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      armed <= 1'b1;
    end else if (CE) begin
      if (match_write) begin
        armed <= 1'b1;
      end else if (fire && !irq_repeat_select) begin
        armed <= 1'b0;
      end
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ALARM_PULSE <= 1'b0;
    end else if (CE) begin
      ALARM_PULSE <= fire & irq_repeat_select;
    end
  end

  //--- status, mask and interrupt

  // only bits that the read actually reported are cleared
  assign clear_bits = (rd_done & sel_status) ?
                      captured_status[`ALARM_ZERO_FLAG_BIT:`ALARM_ZERO_FLAG_BIT] : 1'b0;
  assign mask_we    = wr_en & sel_mask;

  alarm_event_status #(
    .EVENTS     (1)
  ) u_status (
    .clk        (SYS_CLK),
    .reset      (RESET),
    .ce         (CE),
    .set_evt    (fire),
    .clear_bits (clear_bits),
    .mask_we    (mask_we),
    .mask_wdata (PWDATA[`ALARM_ZERO_FLAG_BIT:`ALARM_ZERO_FLAG_BIT]),
    .status     (status),
    .mask       (mask),
    .irq        (IRQ)
  );

  assign ALARM_ZERO_FLAG = status[0];

endmodule // rtc_alarm_compare
`default_nettype wire

// >>> verilog/rtc_alarm_regs.vh
// register offsets, field positions and reset values of the alarm-zero compare block
`ifndef RTC_ALARM_REGS_VH
`define RTC_ALARM_REGS_VH

// byte offsets on the register bus
`define OFS_ALARM_SECONDS_MATCH 8'h00
`define OFS_ALARM_MINUTES_MATCH 8'h04
`define OFS_ALARM_HOURS_MATCH   8'h08
`define OFS_ALARM_DATE_MATCH    8'h0C
`define OFS_ALARM_MONTH_MATCH   8'h10
`define OFS_ALARM_WEEKDAY_MATCH 8'h14
`define OFS_INTERRUPT_CONTROL   8'h18
`define OFS_ALARM_STATUS        8'h1C
`define OFS_IRQ_MASK            8'h20
`define OFS_ALARM_STATE         8'h24

// alarm match register fields
`define MATCH_ENABLE_BIT        7
`define MATCH_VALUE_MSB         6

// interrupt control fields
`define IRQ_REPEAT_SELECT_BIT   7
`define ALARM_ZERO_ENABLE_BIT   5

// status and mask fields
`define ALARM_ZERO_FLAG_BIT     0

// alarm state fields (read only)
`define STATE_ARMED_BIT         0
`define STATE_LAST_MATCH_BIT    1
`define STATE_MATCH_NOW_BIT     2

// reset values
`define MATCH_RESET             8'h00
`define INTERRUPT_CONTROL_RESET 8'h00
`define IRQ_MASK_RESET          1'b0

`endif
